// file: bench/pin_partner.sv
`timescale 1ns/1ps
// ****
// far-side signals on the timer pins
// ****
module pin_partner (
  input wire logic pclk, // bus clock
  input wire logic ext_run, // external clock runs while high
  input wire logic level0, // level driven on channel 0 pin
  input wire logic level1, // level driven on channel 1 pin
  input wire logic out0, // timer drive value, channel 0
  input wire logic oe0, // timer drive enable, channel 0
  input wire logic out1, // timer drive value, channel 1
  input wire logic oe1, // timer drive enable, channel 1
  output logic ext_clk, // external counter clock
  output logic pin0, // resolved channel 0 wire
  output logic pin1 // resolved channel 1 wire
);
  logic [3:0] div = 4'h0;
  // external clock of 16 bus cycles, held low outside its run
  always @(posedge pclk) begin
    if (ext_run) div <= div + 4'h1;
    else div <= 4'h0;
  end
  assign ext_clk = div[3];
  // wire level: the timer wins while it drives the pin
  assign pin0 = oe0 ? out0 : level0;
  assign pin1 = oe1 ? out1 : level1;
endmodule

// file: bench/two_channel_capture_compare_pwm_tb.sv
`timescale 1ns/1ps
`include "timer_defines.svh"
// ****
// self-checking bench
// ****
module two_channel_capture_compare_pwm_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, last_err, ext_run = 1'b0, lv0 = 1'b0, lv1 = 1'b0, ce = 1'b1;
  logic ext_clk, pin0, pin1, out0, oe0, out1, oe1, ovf_irq;
  logic [1:0] ch_irq;
  int err_total = 0, checked = 0, cyc = 0, seed = 32'h50736a0d;
  // clock and cycle count
  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  capture_compare_timer u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_timer_clock_pin(ext_clk), .channel0_pin_in(pin0), .channel0_pin_out(out0), .channel0_pin_oe(oe0),
    .channel1_pin_in(pin1), .channel1_pin_out(out1), .channel1_pin_oe(oe1), .overflow_irq(ovf_irq),
    .channel_irq(ch_irq));
  pin_partner u_pins (.pclk(pclk), .ext_run(ext_run), .level0(lv0), .level1(lv1), .out0(out0), .oe0(oe0),
    .out1(out1), .oe1(oe1), .ext_clk(ext_clk), .pin0(pin0), .pin1(pin1));
  // ****
  // checks and report
  // ****
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  // counter ticks expected over n bus cycles; the external clock period is 16
  function automatic logic [31:0] exp_ticks(input int ps, input int n);
    return (ps == 7) ? 32'(n / 16) : 32'(n >> ps);
  endfunction
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // apb master: setup, then access until pready
  // ****
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(a, 1'b0, 32'h0, q);
  endtask
  // high cycles and rising edges of the channel 0 pin over n cycles
  task automatic meas(input int n, output int hi, output int rs);
    logic p;
    hi = 0;
    rs = 0;
    p = out0;
    repeat (n) begin
      @(posedge pclk);
      if (out0 === 1'b1) hi++;
      if (out0 === 1'b1 && p !== 1'b1) rs++;
      p = out0;
    end
  endtask
  // stop and reset, load period and width, set mode, start
  task automatic pwm_setup(input logic [31:0] sc, input int w);
    wr(`TMR_SC_OFS, 32'h30);
    wr(`TMR_MOD_OFS, 32'hff);
    wr(`TMR_CH0VAL_OFS, 32'(w));
    wr(`TMR_CH0SC_OFS, sc);
    wr(`TMR_SC_OFS, 32'h00);
    repeat (300) @(posedge pclk);
  endtask
  // ****
  // main sequence
  // ****
  initial begin : main
    logic [31:0] q, c1, c2;
    int t0, hi, rs, w, v;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMR_SC_OFS, q);
    chk_reg(q, 32'h20);
    rd(`TMR_MOD_OFS, q);
    chk_reg(q, 32'hffff);
    rd(8'h1c, q);
    chk_bit(last_err, 1'b1);
    chk_reg(q, 32'h0);
    done("reset");
    // every prescale code: count over a window of 256 bus cycles
    for (int ps = 0; ps < 8; ps++) begin
      ext_run <= (ps == 7);
      wr(`TMR_SC_OFS, 32'h10 | 32'(ps));
      rd(`TMR_SC_OFS, q);
      chk_reg(q, 32'(ps));
      @(posedge pclk);
      t0 = cyc;
      rd(`TMR_CNT_OFS, c1);
      while (cyc - t0 < 256) @(posedge pclk);
      rd(`TMR_CNT_OFS, c2);
      chk_reg(c2 - c1, exp_ticks(ps, 256));
    end
    ext_run <= 1'b0;
    // clock enable low for 40 cycles freezes the counter
    wr(`TMR_SC_OFS, 32'h10);
    @(posedge pclk);
    t0 = cyc;
    rd(`TMR_CNT_OFS, c1);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    while (cyc - t0 < 256) @(posedge pclk);
    rd(`TMR_CNT_OFS, c2);
    chk_reg(c2 - c1, exp_ticks(0, 216));
    done("prescale");
    // capture on a held counter, rising then falling polarity
    wr(`TMR_SC_OFS, 32'h00);
    repeat (20 + ($random(seed) & 63)) @(posedge pclk);
    wr(`TMR_SC_OFS, 32'h20);
    rd(`TMR_CNT_OFS, c1);
    wr(`TMR_CH1SC_OFS, 32'h44);
    lv1 <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(`TMR_CH1VAL_OFS, q);
    chk_reg(q, c1);
    chk_bit(ch_irq[1], 1'b1);
    wr(`TMR_SC_OFS, 32'h30);
    wr(`TMR_CH1SC_OFS, 32'h48);
    lv1 <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(`TMR_CH1VAL_OFS, q);
    chk_reg(q, 32'h0);
    wr(`TMR_SC_OFS, 32'h00);
    repeat (20) @(posedge pclk);
    wr(`TMR_SC_OFS, 32'h20);
    lv1 <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(`TMR_CH1VAL_OFS, q);
    chk_reg(q, 32'h0);
    // both polarities on channel 0: a falling edge captures too
    lv0 <= 1'b1;
    rd(`TMR_CNT_OFS, c1);
    wr(`TMR_CH0SC_OFS, 32'h4c);
    lv0 <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(`TMR_CH0VAL_OFS, q);
    chk_reg(q, c1);
    chk_bit(ch_irq[0], 1'b1);
    done("capture");
    // compare actions set, clear, toggle on channel 1
    for (int i = 3; i > 0; i--) begin
      v = 16 + ($random(seed) & 31);
      wr(`TMR_SC_OFS, 32'h30);
      wr(`TMR_CH1VAL_OFS, 32'(v));
      wr(`TMR_CH1SC_OFS, 32'h10 | 32'(i << 2));
      wr(`TMR_SC_OFS, 32'h00);
      repeat (80) @(posedge pclk);
      chk_bit(out1, i != 2);
      chk_bit(oe1, 1'b1);
    end
    wr(`TMR_CH1VAL_OFS, 32'(v - 8));
    repeat (80) @(posedge pclk);
    chk_bit(out1, 1'b1);
    wr(`TMR_CH1VAL_OFS, 32'h100);
    repeat (120) @(posedge pclk);
    chk_bit(out1, 1'b0);
    done("compare");
    // unbuffered pwm, then 0% and 100% duty
    w = 32 + ($random(seed) & 127);
    pwm_setup(32'h1a, w);
    meas(512, hi, rs);
    chk_reg(32'(hi), 32'(2 * w));
    chk_reg(32'(rs), 32'h2);
    chk_bit(oe0, 1'b1);
    rd(`TMR_SC_OFS, q);
    chk_reg(q, 32'h80);
    chk_bit(ovf_irq, 1'b0);
    wr(`TMR_SC_OFS, 32'h40);
    repeat (260) @(posedge pclk);
    chk_bit(ovf_irq, 1'b1);
    pwm_setup(32'h18, w);
    meas(512, hi, rs);
    chk_reg(32'(hi), 32'h0);
    pwm_setup(32'h19, w);
    meas(512, hi, rs);
    chk_reg(32'(hi), 32'h200);
    done("pwm");
    // linked pair: widths follow the last-written value pair
    wr(`TMR_CH1SC_OFS, 32'h18);
    pwm_setup(32'h3a, w);
    meas(256, hi, rs);
    chk_reg(32'(hi), 32'(w));
    chk_bit(oe1, 1'b0);
    wr(`TMR_CH1VAL_OFS, 32'(w + 40));
    repeat (300) @(posedge pclk);
    meas(256, hi, rs);
    chk_reg(32'(hi), 32'(w + 40));
    wr(`TMR_CH0VAL_OFS, 32'(w / 2));
    repeat (300) @(posedge pclk);
    meas(256, hi, rs);
    chk_reg(32'(hi), 32'(w / 2));
    done("buffered");
    results();
  end
endmodule

// file: include/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// register byte offsets
`define TMR_SC_OFS 8'h00
`define TMR_CNT_OFS 8'h04
`define TMR_MOD_OFS 8'h08
`define TMR_CH0SC_OFS 8'h0c
`define TMR_CH0VAL_OFS 8'h10
`define TMR_CH1SC_OFS 8'h14
`define TMR_CH1VAL_OFS 8'h18
// timer status/control fields
`define SC_FLAG_BIT 7
`define SC_IRQEN_BIT 6
`define SC_STOP_BIT 5
`define SC_RST_BIT 4
`define SC_PS_MSB 2
// channel status/control fields
`define CHSC_FLAG_BIT 7
`define CHSC_CTRL_MSB 6
// reset values
`define SC_STOP_RST 1'b1
`define MOD_RST 16'hffff
// encodings
`define PS_EXT_CLOCK 3'h7
`define ELS_OFF 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
`endif

// file: include/timer_pkg.sv
package timer_pkg;
  typedef enum logic [1:0] {MODE_IDLE, MODE_CAPTURE, MODE_UNBUF, MODE_BUF} chan_mode_e;
  // channel status/control, bits 6..0
  typedef struct packed {
    logic irq_en;
    logic buf_sel;
    logic unbuf_sel;
    logic [1:0] edge_level;
    logic tov;
    logic max_duty;
  } chan_ctrl_s;
  typedef struct packed {
    logic ovf_irq_en;
    logic stop;
    logic [2:0] prescale_select;
  } timer_ctrl_s;
endpackage

// file: logic/capture_compare_timer.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "timer_defines.svh"

// How it works
// - counter ticks from a bus-clock prescaler tap or the external clock pin
// - select 0..6 divides by 1,2,4..64; select 7 uses the external clock pin
// - counter wraps to zero after equalling modulo and sets the overflow flag
// - counter reset bit clears counter and prescaler, self-clears, reads zero
// - capture edge on a pin copies the counter into that channel value
// - capture edge polarity is programmable per channel
// - capture and compare events set channel flags that raise an interrupt
// - compare match sets, clears or toggles the channel pin
// - unbuffered value writes take effect at once; passed values miss
// - channel 0 buffered select links both channels onto the channel 0 pin
// - linked: last-written value pair takes control at each overflow
// - linked: channel 1 control unused and its pin released
// - toggle-on-overflow toggles the pin at wrap, modulo sets the period
// - pulse width runs from overflow to the compare match
// - modulo 255 with select 0 gives a 256 bus clock period
// - mode 01 unbuffered, 10 buffered on channel 0; edge 10 clears, 11 sets on compare
// - buffered select wins over unbuffered select on channel 0
// - without toggle-on-overflow, redundant compares leave the pin alone
// - max duty bit forces a constant high output
module capture_compare_timer (
  input wire logic pclk, // bus clock, 125 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_timer_clock_pin, // external counter clock
  input wire logic channel0_pin_in, // channel 0 pin level
  output logic channel0_pin_out, // channel 0 pin drive value
  output logic channel0_pin_oe, // channel 0 pin drive enable
  input wire logic channel1_pin_in, // channel 1 pin level
  output logic channel1_pin_out, // channel 1 pin drive value
  output logic channel1_pin_oe, // channel 1 pin drive enable
  output logic overflow_irq, // overflow interrupt request
  output logic [1:0] channel_irq // channel interrupt requests
);
  // ****************************************
  // state and decode
  // ****************************************
  timer_pkg::timer_ctrl_s tctrl_reg;
  timer_pkg::chan_ctrl_s chan_ctrl_reg [2];
  timer_pkg::chan_mode_e mode [2];
  logic [15:0] count_reg, count_next, modulo_reg;
  logic [15:0] value_reg [2];
  logic [15:0] act_val [2];
  logic [5:0] pre_reg, pre_mask;
  logic ovf_flag_reg, ovf_arm_reg, act_sel_reg, pend_sel_reg, pready_reg;
  logic [1:0] ch_flag_reg, ch_arm_reg, pin_out_reg, pin_in, pin_level, pin_prev;
  logic [1:0] cap_evt, cmp_evt, out_mode, drive;
  logic [2:0] ext_sync_reg;
  logic ext_level_reg, ext_prev_reg, ext_rise;
  logic [2:0] pin_sync_reg [2];
  logic [31:0] prdata_reg;
  logic pslverr_reg, wr_done, rd_done, cnt_rst, tick_src, tick, ovf_evt, linked;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `TMR_SC_OFS || a == `TMR_CNT_OFS || a == `TMR_MOD_OFS || a == `TMR_CH0SC_OFS ||
           a == `TMR_CH0VAL_OFS || a == `TMR_CH1SC_OFS || a == `TMR_CH1VAL_OFS;
  endfunction

  function automatic timer_pkg::chan_mode_e chan_mode(input timer_pkg::chan_ctrl_s c, input logic ch1,
                                                      input logic lnk);
    if (ch1 && lnk) return timer_pkg::MODE_IDLE;
    else if (!ch1 && c.buf_sel) return timer_pkg::MODE_BUF;
    else if (c.unbuf_sel || c.buf_sel) return timer_pkg::MODE_UNBUF;
    else return timer_pkg::MODE_CAPTURE;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      `TMR_SC_OFS: return {24'h0, ovf_flag_reg, tctrl_reg.ovf_irq_en, tctrl_reg.stop, 2'h0,
                           tctrl_reg.prescale_select};
      `TMR_CNT_OFS: return {16'h0, count_reg};
      `TMR_MOD_OFS: return {16'h0, modulo_reg};
      `TMR_CH0SC_OFS: return {24'h0, ch_flag_reg[0], chan_ctrl_reg[0]};
      `TMR_CH0VAL_OFS: return {16'h0, value_reg[0]};
      `TMR_CH1SC_OFS: return {24'h0, ch_flag_reg[1], chan_ctrl_reg[1]};
      `TMR_CH1VAL_OFS: return {16'h0, value_reg[1]};
      default: return 32'h0;
    endcase
  endfunction

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  assign wr_done = psel && penable && pready_reg && pwrite && is_mapped(paddr);
  assign rd_done = psel && penable && pready_reg && !pwrite;
  assign cnt_rst = wr_done && paddr == `TMR_SC_OFS && pwdata[`SC_RST_BIT];
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // ready, read data and error captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0 : read_word(paddr);
        pslverr_reg <= !is_mapped(paddr);
      end
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctrl_reg <= '{ovf_irq_en: 1'b0, stop: `SC_STOP_RST, prescale_select: 3'h0};
      modulo_reg <= `MOD_RST;
      chan_ctrl_reg[0] <= '0;
      chan_ctrl_reg[1] <= '0;
    end else if (ce && wr_done) begin
      if (paddr == `TMR_SC_OFS)
        tctrl_reg <= {pwdata[`SC_IRQEN_BIT], pwdata[`SC_STOP_BIT], pwdata[`SC_PS_MSB:0]};
      if (paddr == `TMR_MOD_OFS) modulo_reg <= pwdata[15:0];
      if (paddr == `TMR_CH0SC_OFS) chan_ctrl_reg[0] <= pwdata[`CHSC_CTRL_MSB:0];
      if (paddr == `TMR_CH1SC_OFS) chan_ctrl_reg[1] <= pwdata[`CHSC_CTRL_MSB:0];
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  assign pin_in = {channel1_pin_in, channel0_pin_in};

  // external clock, level accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_reg <= 3'h0;
      ext_level_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (ce) begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_timer_clock_pin};
      if (ext_sync_reg[1] == ext_sync_reg[2]) ext_level_reg <= ext_sync_reg[2];
      ext_prev_reg <= ext_level_reg;
    end
  end
  assign ext_rise = ext_level_reg && !ext_prev_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      // channel pin sampled the same way as the clock pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_sync_reg[g] <= 3'h0;
          pin_level[g] <= 1'b0;
          pin_prev[g] <= 1'b0;
        end else if (ce) begin
          pin_sync_reg[g] <= {pin_sync_reg[g][1:0], pin_in[g]};
          if (pin_sync_reg[g][1] == pin_sync_reg[g][2]) pin_level[g] <= pin_sync_reg[g][2];
          pin_prev[g] <= pin_level[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // prescaler and counter
  // ****************************************
  assign pre_mask = 6'((7'h1 << tctrl_reg.prescale_select) - 7'h1);
  assign tick_src = (tctrl_reg.prescale_select == `PS_EXT_CLOCK) ? ext_rise : ((pre_reg & pre_mask) == pre_mask);
  assign tick = tick_src && !tctrl_reg.stop && !cnt_rst;
  assign ovf_evt = tick && count_reg == modulo_reg;
  assign count_next = (count_reg == modulo_reg) ? 16'h0 : count_reg + 16'h1;

  // prescaler and counter, both cleared by the reset bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h0;
      count_reg <= 16'h0;
    end else if (ce) begin
      if (cnt_rst) begin
        pre_reg <= 6'h0;
        count_reg <= 16'h0;
      end else begin
        if (!tctrl_reg.stop) pre_reg <= pre_reg + 6'h1;
        if (tick) count_reg <= count_next;
      end
    end
  end

  // overflow flag: read while set arms it, writing zero then clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else if (ce) begin
      if (ovf_evt) ovf_flag_reg <= 1'b1;
      else if (wr_done && paddr == `TMR_SC_OFS && ovf_arm_reg && !pwdata[`SC_FLAG_BIT]) ovf_flag_reg <= 1'b0;
      if (wr_done && paddr == `TMR_SC_OFS) ovf_arm_reg <= 1'b0;
      else if (rd_done && paddr == `TMR_SC_OFS && ovf_flag_reg) ovf_arm_reg <= 1'b1;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  assign linked = chan_ctrl_reg[0].buf_sel;

  // link buffer select: last written pair takes over at overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_reg <= 1'b0;
      pend_sel_reg <= 1'b0;
    end else if (ce) begin
      if (!linked) begin
        act_sel_reg <= 1'b0;
        pend_sel_reg <= 1'b0;
      end else begin
        if (wr_done && paddr == `TMR_CH1VAL_OFS) pend_sel_reg <= 1'b1;
        else if (wr_done && paddr == `TMR_CH0VAL_OFS) pend_sel_reg <= 1'b0;
        if (ovf_evt) act_sel_reg <= pend_sel_reg;
      end
    end
  end

  // per channel decode, capture edges and compare matches
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode[i] = chan_mode(chan_ctrl_reg[i], i == 1, linked);
      out_mode[i] = mode[i] == timer_pkg::MODE_UNBUF || mode[i] == timer_pkg::MODE_BUF;
      drive[i] = out_mode[i] && chan_ctrl_reg[i].edge_level != `ELS_OFF;
      act_val[i] = (i == 0 && mode[0] == timer_pkg::MODE_BUF && act_sel_reg) ? value_reg[1] : value_reg[i];
      cmp_evt[i] = out_mode[i] && tick && count_next == act_val[i];
      cap_evt[i] = mode[i] == timer_pkg::MODE_CAPTURE &&
                   ((chan_ctrl_reg[i].edge_level[0] && pin_level[i] && !pin_prev[i]) ||
                    (chan_ctrl_reg[i].edge_level[1] && !pin_level[i] && pin_prev[i]));
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_chan
      // channel value: capture wins over a bus write in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) value_reg[g] <= 16'h0;
        else if (ce) begin
          if (cap_evt[g]) value_reg[g] <= count_reg;
          else if (wr_done && paddr == (g == 0 ? `TMR_CH0VAL_OFS : `TMR_CH1VAL_OFS)) value_reg[g] <= pwdata[15:0];
        end
      end

      // channel flag, cleared like the overflow flag; event wins
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_flag_reg[g] <= 1'b0;
          ch_arm_reg[g] <= 1'b0;
        end else if (ce) begin
          if (cap_evt[g] || cmp_evt[g]) ch_flag_reg[g] <= 1'b1;
          else if (wr_done && paddr == (g == 0 ? `TMR_CH0SC_OFS : `TMR_CH1SC_OFS) && ch_arm_reg[g] &&
                   !pwdata[`CHSC_FLAG_BIT]) ch_flag_reg[g] <= 1'b0;
          if (wr_done && paddr == (g == 0 ? `TMR_CH0SC_OFS : `TMR_CH1SC_OFS)) ch_arm_reg[g] <= 1'b0;
          else if (rd_done && paddr == (g == 0 ? `TMR_CH0SC_OFS : `TMR_CH1SC_OFS) && ch_flag_reg[g])
            ch_arm_reg[g] <= 1'b1;
        end
      end

      // pin action: max duty, then compare, then toggle on overflow
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pin_out_reg[g] <= 1'b0;
        else if (ce && out_mode[g]) begin
          if (chan_ctrl_reg[g].max_duty) pin_out_reg[g] <= 1'b1;
          else if (cmp_evt[g]) begin
            unique case (chan_ctrl_reg[g].edge_level)
              `ELS_TOGGLE: pin_out_reg[g] <= !pin_out_reg[g];
              `ELS_CLEAR: pin_out_reg[g] <= 1'b0;
              `ELS_SET: pin_out_reg[g] <= 1'b1;
              `ELS_OFF: pin_out_reg[g] <= pin_out_reg[g];
            endcase
          end else if (ovf_evt && chan_ctrl_reg[g].tov) pin_out_reg[g] <= !pin_out_reg[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign channel0_pin_out = pin_out_reg[0];
  assign channel1_pin_out = pin_out_reg[1];
  assign channel0_pin_oe = drive[0];
  assign channel1_pin_oe = drive[1];
  assign overflow_irq = ovf_flag_reg && tctrl_reg.ovf_irq_en;
  assign channel_irq = {ch_flag_reg[1] && chan_ctrl_reg[1].irq_en, ch_flag_reg[0] && chan_ctrl_reg[0].irq_en};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prescale_div_one: assert property (ce && tctrl_reg.prescale_select == 3'h0 && !tctrl_reg.stop && !cnt_rst
    |-> tick) else $error("divide by one missed a tick");
  a_rollover_to_zero: assert property (ce && ovf_evt |=> count_reg == 16'h0 && ovf_flag_reg)
    else $error("no wrap or flag at modulo");
  a_counter_reset_clear: assert property (ce && cnt_rst |=> count_reg == 16'h0 && pre_reg == 6'h0)
    else $error("counter reset did not clear");
  a_reset_bit_zero: assert property (pready && !pwrite && paddr == `TMR_SC_OFS |-> !prdata[`SC_RST_BIT])
    else $error("reset bit read as one");
  a_capture_copies: assert property (ce && cap_evt[0] |=> value_reg[0] == $past(count_reg))
    else $error("capture value wrong");
  a_flag_on_event: assert property (ce && (cap_evt[1] || cmp_evt[1]) |=> ch_flag_reg[1])
    else $error("channel flag not set");
  a_compare_clears: assert property (ce && cmp_evt[0] && !chan_ctrl_reg[0].max_duty &&
    chan_ctrl_reg[0].edge_level == `ELS_CLEAR |=> !channel0_pin_out) else $error("clear on compare failed");
  a_buffer_swap: assert property (ce && ovf_evt && linked |=> act_sel_reg == $past(pend_sel_reg))
    else $error("buffer pair not handed over");
  a_linked_release: assert property (linked |-> !channel1_pin_oe) else $error("channel 1 pin driven while linked");
  a_max_duty_high: assert property (ce && out_mode[0] && chan_ctrl_reg[0].max_duty |=> channel0_pin_out)
    else $error("max duty not high");
  a_pin_release: assert property (!out_mode[0] |-> !channel0_pin_oe) else $error("pin driven outside compare");

  c_overflow: cover property (ce && ovf_evt);
  c_capture: cover property (ce && cap_evt[0]);
  c_linked_compare: cover property (ce && cmp_evt[0] && linked && act_sel_reg);
  c_ext_clock: cover property (ce && tick && tctrl_reg.prescale_select == `PS_EXT_CLOCK);
endmodule
